/* File: logic/network_time_capture.sv */
`timescale 1ns/100ps
module network_time_capture #(
  parameter int unsigned PROC_CYCLES = ntc_pkg::REQ_PROC_CYCLES
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic time_strobe_n, // Time strobe pin, capture on rising edge
  input wire logic read_req, // Read-time request pulse from the API parser
  input wire logic xtal32_tick_in, // Slow crystal clock pin, sampled
  input wire logic xtal32_running, // Slow crystal has started oscillating
  input wire logic api_rx, // API serial receive line
  input wire logic api_rx_rts_n, // API receive request line
  input wire logic cli_rx, // CLI serial receive line
  input wire logic serial_busy, // A serial transfer is in progress
  input wire logic radio_need, // Radio requests its reference crystal
  input wire logic doze_req, // Software asks to enter doze
  input wire logic pkt_ready, // Packet sink accepts the packet
  output logic pkt_valid, // Time packet available
  output logic [ntc_pkg::TS_W-1:0] pkt_time, // Timestamp in nanoseconds
  output logic pkt_src, // 0 strobe, 1 read request
  output logic req_busy, // Read request still in processing
  output logic strobe_overrun, // Strobe arrived before previous one was sent
  output logic dozing, // Device is in doze state
  output logic xtal32_en, // Slow crystal enable
  output logic xtal20_en // Radio reference crystal enable
);

  logic strobe_rise;
  logic tick_rise;
  logic [ntc_pkg::ACT_W-1:0] act_rise;
  logic [ntc_pkg::ACT_W-1:0] act_fall;
  logic [ntc_pkg::ACT_W-1:0] act_level;
  logic [ntc_pkg::ACT_W-1:0] act_raw;
  logic activity;

  // Pin sampling: strobe idles high so the reset value avoids a false edge
  // synchronised strobe edge
  ntc_sync_edge #(.W(1), .INIT(1'h1)) u_strobe_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(time_strobe_n),
    .sync_out(),
    .rise(strobe_rise),
    .fall()
  );

  ntc_sync_edge #(.W(1), .INIT(1'h0)) u_tick_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(xtal32_tick_in),
    .sync_out(),
    .rise(tick_rise),
    .fall()
  );

  assign act_raw = {cli_rx, api_rx_rts_n, api_rx};

  ntc_sync_edge #(.W(ntc_pkg::ACT_W), .INIT(ntc_pkg::ACT_IDLE)) u_act_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(act_raw),
    .sync_out(act_level),
    .rise(act_rise),
    .fall(act_fall)
  );

  // Any edge or non-idle level counts as serial activity
  assign activity = (|act_rise) | (|act_fall) | (|(act_level ^ ntc_pkg::ACT_IDLE));

  // Network time base
  logic [ntc_pkg::TS_W-1:0] net_time;
  logic [ntc_pkg::TS_W-1:0] next_net_time;
  ntc_pkg::ntc_pwr_e pwr;
  ntc_pkg::ntc_pwr_e next_pwr;

  // Time advances per core cycle when active, per crystal tick when dozing
  always_comb begin
    next_net_time = net_time;
    if (pwr == ntc_pkg::NTC_ACTIVE) begin
      next_net_time = net_time + ntc_pkg::TS_W'(ntc_pkg::CLK_PERIOD_NS);
    end else if (tick_rise) begin
      next_net_time = net_time + ntc_pkg::TS_W'(ntc_pkg::XTAL32_STEP_NS);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      net_time <= '0;
    end else begin
      net_time <= next_net_time;
    end
  end

  // Strobe capture and request processing
  logic strb_pend;
  logic next_strb_pend;
  logic [ntc_pkg::TS_W-1:0] strb_time;
  logic [ntc_pkg::TS_W-1:0] next_strb_time;
  logic req_pend;
  logic next_req_pend;
  logic [ntc_pkg::TS_W-1:0] req_time;
  logic [ntc_pkg::TS_W-1:0] next_req_time;
  logic [ntc_pkg::PROC_CNT_W-1:0] proc_cnt;
  logic [ntc_pkg::PROC_CNT_W-1:0] next_proc_cnt;
  logic next_req_busy;
  logic next_overrun;
  logic take_strb;
  logic take_req;
  logic slot_free;

  // Output slot frees when empty or being accepted; strobe has priority
  assign slot_free = !pkt_valid || pkt_ready;
  assign take_strb = slot_free && strb_pend;
  assign take_req = slot_free && !strb_pend && req_pend;

  always_comb begin
    next_strb_pend = strb_pend;
    next_strb_time = strb_time;
    next_overrun = 1'b0;
    next_req_pend = req_pend;
    next_req_time = req_time;
    next_proc_cnt = proc_cnt;
    next_req_busy = req_busy;
    if (take_strb) begin
      next_strb_pend = 1'b0;
    end
    if (strobe_rise) begin
      next_strb_time = net_time;
      next_strb_pend = 1'b1;
      next_overrun = strb_pend && !take_strb;
    end
    if (take_req) begin
      next_req_pend = 1'b0;
    end
    if (req_busy) begin
      if (proc_cnt == '0) begin
        next_req_busy = 1'b0;
        next_req_time = net_time;
        next_req_pend = 1'b1;
      end else begin
        next_proc_cnt = proc_cnt - 1'b1;
      end
    end else if (read_req && !req_pend) begin
      next_req_busy = 1'b1;
      next_proc_cnt = ntc_pkg::PROC_CNT_W'(PROC_CYCLES - 1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strb_pend <= 1'b0;
      strb_time <= '0;
      strobe_overrun <= 1'b0;
      req_pend <= 1'b0;
      req_time <= '0;
      proc_cnt <= '0;
      req_busy <= 1'b0;
    end else begin
      strb_pend <= next_strb_pend;
      strb_time <= next_strb_time;
      strobe_overrun <= next_overrun;
      req_pend <= next_req_pend;
      req_time <= next_req_time;
      proc_cnt <= next_proc_cnt;
      req_busy <= next_req_busy;
    end
  end

  // Packet output
  logic next_pkt_valid;
  logic [ntc_pkg::TS_W-1:0] next_pkt_time;
  logic next_pkt_src;

  // Packet held until accepted, then the next pending one is loaded
  always_comb begin
    next_pkt_valid = pkt_valid && !pkt_ready;
    next_pkt_time = pkt_time;
    next_pkt_src = pkt_src;
    if (take_strb) begin
      next_pkt_valid = 1'b1;
      next_pkt_time = strb_time;
      next_pkt_src = ntc_pkg::PKT_SRC_STROBE;
    end else if (take_req) begin
      next_pkt_valid = 1'b1;
      next_pkt_time = req_time;
      next_pkt_src = ntc_pkg::PKT_SRC_REQUEST;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pkt_valid <= 1'b0;
      pkt_time <= '0;
      pkt_src <= ntc_pkg::PKT_SRC_STROBE;
    end else begin
      pkt_valid <= next_pkt_valid;
      pkt_time <= next_pkt_time;
      pkt_src <= next_pkt_src;
    end
  end

  // Power state and oscillator control
  logic work_left;
  logic next_dozing;
  logic next_xtal32_en;
  logic next_xtal20_en;

  assign work_left = strb_pend || req_pend || req_busy || pkt_valid;

  // doze only once serial transfers and packets are done
  always_comb begin
    next_pwr = pwr;
    unique case (pwr)
      ntc_pkg::NTC_ACTIVE: begin
        if (doze_req && !serial_busy && !activity && !work_left && !radio_need) begin
          next_pwr = ntc_pkg::NTC_DOZE;
        end
      end
      ntc_pkg::NTC_DOZE: begin
        if (activity || strobe_rise || read_req || radio_need || !doze_req) begin
          next_pwr = ntc_pkg::NTC_ACTIVE;
        end
      end
    endcase
    next_dozing = (next_pwr == ntc_pkg::NTC_DOZE);
    // slow crystal stays on once running
    next_xtal32_en = xtal32_en || xtal32_running;
    next_xtal20_en = radio_need;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr <= ntc_pkg::NTC_ACTIVE;
      dozing <= 1'b0;
      xtal32_en <= 1'b1;
      xtal20_en <= 1'b0;
    end else begin
      pwr <= next_pwr;
      dozing <= next_dozing;
      xtal32_en <= next_xtal32_en;
      xtal20_en <= next_xtal20_en;
    end
  end

endmodule // network_time_capture

/* File: logic/ntc_pkg.sv */
package ntc_pkg;

  // Clock and timestamp format
  localparam int unsigned CLK_FREQ_HZ = 100000000;
  localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_FREQ_HZ;
  localparam int unsigned TS_W = 48;
  // Nominal core oscillator target, not used by any logic here
  localparam int unsigned RELAX_TARGET_HZ = 7372800;
  // Slow crystal used as time base while dozing
  localparam int unsigned XTAL32_HZ = 32768;
  localparam int unsigned XTAL32_STEP_NS = 1000000000 / XTAL32_HZ;
  // Read-time request processing latency, in microseconds
  localparam int unsigned REQ_PROC_TIME_US = 2000;
  localparam int unsigned REQ_PROC_CYCLES = REQ_PROC_TIME_US * (CLK_FREQ_HZ / 1000000);
  localparam int unsigned PROC_CNT_W = 24;

  // Serial activity lines watched for wake-up
  localparam int unsigned ACT_W = 3;
  localparam int unsigned ACT_API_RX = 0;
  localparam int unsigned ACT_API_RTS = 1;
  localparam int unsigned ACT_CLI_RX = 2;
  // Idle level of each activity line (all idle high)
  localparam logic [ACT_W-1:0] ACT_IDLE = 3'h7;

  // Packet source codes
  localparam logic PKT_SRC_STROBE = 1'h0;
  localparam logic PKT_SRC_REQUEST = 1'h1;

  // Power states
  typedef enum logic [0:0] {
    NTC_ACTIVE = 1'b0,
    NTC_DOZE = 1'b1
  } ntc_pwr_e;

endpackage

/* File: logic/ntc_sync_edge.sv */
`timescale 1ns/100ps
module ntc_sync_edge #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [W-1:0] async_in, // Raw pin levels
  output logic [W-1:0] sync_out, // Synchronised levels
  output logic [W-1:0] rise, // One-cycle rising edge pulses
  output logic [W-1:0] fall // One-cycle falling edge pulses
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] stage;
  logic [W-1:0] next_stage;
  logic [W-1:0] last;
  logic [W-1:0] next_last;

  // Next values per bit
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_comb begin
        next_meta[g] = async_in[g];
        next_stage[g] = meta[g];
        next_last[g] = stage[g];
      end
    end
  endgenerate

  // Two flip-flops, then a history stage for edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= INIT;
      stage <= INIT;
      last <= INIT;
    end else begin
      meta <= next_meta;
      stage <= next_stage;
      last <= next_last;
    end
  end

  // Edge detection looks only at the second stage and its history
  assign sync_out = stage;
  assign rise = stage & ~last;
  assign fall = ~stage & last;

endmodule // ntc_sync_edge

/* File: verif/ntc_assertions.sv */
`timescale 1ns/100ps
module ntc_assertions #(
  parameter int unsigned PROC_CYCLES = 8
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic time_strobe_n, // Strobe pin
  input wire logic api_rx, // Serial line
  input wire logic serial_busy, // Transfer busy
  input wire logic radio_need, // Radio need
  input wire logic doze_req, // Doze request
  input wire logic pkt_ready, // Sink ready
  input wire logic pkt_valid, // Packet valid
  input wire logic pkt_src, // Packet source
  input wire logic req_busy, // Request busy
  input wire logic dozing, // Doze state
  input wire logic xtal20_en // Radio crystal
);
  logic [23:0] busy_cnt;
  logic [23:0] next_busy_cnt;
  // Length of the current request processing span
  always_comb next_busy_cnt = req_busy ? busy_cnt + 24'h1 : 24'h0;
  always_ff @(posedge clk) busy_cnt <= rst_n ? next_busy_cnt : 24'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_strobe_edge;
    !time_strobe_n ##1 time_strobe_n;
  endsequence
  sequence s_strobe_pkt;
    ##[2:6] (pkt_valid && !pkt_src);
  endsequence
  a_strobe_pkt: assert property (s_strobe_edge |-> s_strobe_pkt)
    else $error("no packet after strobe");
  a_pkt_held: assert property (pkt_valid && !pkt_ready |=> pkt_valid)
    else $error("packet dropped unsent");
  a_req_span: assert property ($fell(req_busy) |->
    busy_cnt inside {[PROC_CYCLES:PROC_CYCLES + 1]})
    else $error("request span wrong");
  a_req_pkt: assert property ($fell(req_busy) |-> ##[0:3] (pkt_valid && pkt_src))
    else $error("no request packet");
  a_xtal20_on: assert property (radio_need |=> xtal20_en)
    else $error("radio crystal off");
  a_xtal20_off: assert property (!radio_need |=> !xtal20_en)
    else $error("radio crystal on");
  a_wake_act: assert property (dozing && !api_rx |-> ##[1:5] !dozing)
    else $error("no wake on activity");
  a_wake_release: assert property (dozing && !doze_req |=> !dozing)
    else $error("no wake on release");
  a_busy_nodoze: assert property (!dozing && serial_busy |=> !dozing)
    else $error("doze during transfer");
endmodule // ntc_assertions
bind network_time_capture ntc_assertions #(.PROC_CYCLES(PROC_CYCLES)) i_chk (.*);

/* File: verif/ntc_companion.sv */
`timescale 1ns/100ps
module ntc_companion (
  input wire logic clk, // Clock
  input wire logic stall, // Hold off sink
  input wire logic pkt_valid, // Packet offered
  input wire logic [ntc_pkg::TS_W-1:0] pkt_time, // Timestamp
  input wire logic pkt_src, // Source
  output logic pkt_ready, // Sink ready
  output int n_pkt, // Packets taken
  output logic [ntc_pkg::TS_W-1:0] last_time, // Last timestamp
  output logic last_src // Last source
);
  // Ready moves only after the falling edge
  initial pkt_ready = 1'b0;
  always @(negedge clk) pkt_ready <= !stall;
  // Take a packet when both sides agree at the edge
  initial n_pkt = 0;
  always @(posedge clk) begin
    if (pkt_valid === 1'b1 && pkt_ready) begin
      n_pkt <= n_pkt + 1;
      last_time <= pkt_time;
      last_src <= pkt_src;
    end
  end
endmodule // ntc_companion

/* File: verif/tb.sv */
`timescale 1ns/100ps
module tb;
  localparam int unsigned PC = 8;
  logic clk = 1'b0, rst_n = 1'b0, time_strobe_n = 1'b1, read_req = 1'b0;
  logic xtal32_tick_in = 1'b0, xtal32_running = 1'b1, stall = 1'b0;
  logic api_rx = 1'b1, api_rx_rts_n = 1'b1, cli_rx = 1'b1;
  logic serial_busy = 1'b0, radio_need = 1'b0, doze_req = 1'b0;
  logic pkt_ready, pkt_valid, pkt_src, req_busy, strobe_overrun, dozing;
  logic xtal32_en, xtal20_en, last_src, seen_ovr = 1'b0;
  logic [ntc_pkg::TS_W-1:0] pkt_time, last_time;
  int fails = 0, check_count = 0, cyc = 0, rel_cyc = 0, n_pkt;
  network_time_capture #(.PROC_CYCLES(PC)) i_dut (.clk(clk), .rst_n(rst_n),
    .time_strobe_n(time_strobe_n), .read_req(read_req), .xtal32_tick_in(xtal32_tick_in),
    .xtal32_running(xtal32_running), .api_rx(api_rx), .api_rx_rts_n(api_rx_rts_n),
    .cli_rx(cli_rx), .serial_busy(serial_busy), .radio_need(radio_need), .doze_req(doze_req),
    .pkt_ready(pkt_ready), .pkt_valid(pkt_valid), .pkt_time(pkt_time), .pkt_src(pkt_src),
    .req_busy(req_busy), .strobe_overrun(strobe_overrun), .dozing(dozing),
    .xtal32_en(xtal32_en), .xtal20_en(xtal20_en));
  ntc_companion i_far (.clk(clk), .stall(stall), .pkt_valid(pkt_valid),
    .pkt_time(pkt_time), .pkt_src(pkt_src), .pkt_ready(pkt_ready),
    .n_pkt(n_pkt), .last_time(last_time), .last_src(last_src));
  // Clock, cycle count and overrun watch
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) if (strobe_overrun === 1'b1) seen_ovr <= 1'b1;
  task automatic check(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic results();
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic strobe(output int c);
    time_strobe_n = 1'b0;
    repeat (2) @(negedge clk);
    time_strobe_n = 1'b1;
    c = cyc;
  endtask
  task automatic wait_pkt(input int n);
    for (int i = 0; i < 40 && n_pkt < n; i++) @(negedge clk);
    check(n_pkt == n, "packet missing");
  endtask
  task automatic wait_doze(input logic v);
    for (int i = 0; i < 20 && dozing !== v; i++) @(negedge clk);
    check(dozing === v, "doze state");
  endtask
  task automatic t_strobe();
    logic [47:0] t0;
    int c0, c1, n;
    n = n_pkt;
    strobe(c0);
    wait_pkt(n + 1);
    check(last_src === ntc_pkg::PKT_SRC_STROBE, "strobe source");
    t0 = last_time;
    check(t0 === 48'((c0 + 2 - rel_cyc) * ntc_pkg::CLK_PERIOD_NS), "time base");
    repeat (23) @(negedge clk);
    strobe(c1);
    wait_pkt(n + 2);
    check(last_time - t0 === 48'((c1 - c0) * 10), "capture time");
    repeat (20) @(negedge clk);
    check(n_pkt == n + 2, "strobe count");
  endtask
  task automatic t_request();
    logic [47:0] ts;
    int cs, cr, n, d;
    n = n_pkt;
    strobe(cs);
    wait_pkt(n + 1);
    ts = last_time;
    read_req = 1'b1;
    cr = cyc;
    @(negedge clk);
    read_req = 1'b0;
    @(negedge clk);
    check(req_busy === 1'b1, "not busy");
    read_req = 1'b1;
    @(negedge clk);
    read_req = 1'b0;
    wait_pkt(n + 2);
    d = int'(last_time - ts);
    check(last_src === ntc_pkg::PKT_SRC_REQUEST, "request source");
    check(d >= (cr - cs + PC - 4) * 10 && d <= (cr - cs + PC + 3) * 10, "lag");
    repeat (30) @(negedge clk);
    check(n_pkt == n + 2, "request count");
  endtask
  task automatic t_overrun();
    int c, n;
    n = n_pkt;
    check(seen_ovr === 1'b0, "false overrun");
    stall = 1'b1;
    repeat (3) begin
      strobe(c);
      repeat (8) @(negedge clk);
    end
    check(pkt_valid === 1'b1 && seen_ovr === 1'b1, "overrun");
    stall = 1'b0;
    repeat (20) @(negedge clk);
    check(n_pkt == n + 2 && pkt_valid === 1'b0, "drain");
  endtask
  task automatic t_doze();
    serial_busy = 1'b1;
    doze_req = 1'b1;
    repeat (10) @(negedge clk);
    check(dozing === 1'b0, "doze while busy");
    serial_busy = 1'b0;
    wait_doze(1'b1);
    api_rx = 1'b0;
    wait_doze(1'b0);
    api_rx = 1'b1;
    wait_doze(1'b1);
    radio_need = 1'b1;
    repeat (2) @(negedge clk);
    check(xtal20_en === 1'b1 && dozing === 1'b0, "radio wake");
    radio_need = 1'b0;
    doze_req = 1'b0;
    repeat (2) @(negedge clk);
    check(xtal20_en === 1'b0 && xtal32_en === 1'b1, "crystals");
  endtask
  // Time keeps running on slow ticks while dozing, then doze ends on release
  task automatic t_slow();
    logic [47:0] t0, want;
    int c0, c1, cd, n;
    n = n_pkt;
    strobe(c0);
    wait_pkt(n + 1);
    t0 = last_time;
    doze_req = 1'b1;
    wait_doze(1'b1);
    cd = cyc;
    repeat (3) begin
      xtal32_tick_in = 1'b1;
      repeat (2) @(negedge clk);
      xtal32_tick_in = 1'b0;
      repeat (2) @(negedge clk);
    end
    check(dozing === 1'b1, "tick woke");
    strobe(c1);
    wait_pkt(n + 2);
    want = 48'((cd - c0 - 2) * ntc_pkg::CLK_PERIOD_NS + 3 * ntc_pkg::XTAL32_STEP_NS);
    check(last_time - t0 === want, "doze time base");
    wait_doze(1'b1);
    doze_req = 1'b0;
    repeat (2) @(negedge clk);
    check(dozing === 1'b0, "doze release");
  endtask
  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    rel_cyc = cyc;
    @(negedge clk);
    check(pkt_valid === 1'b0 && req_busy === 1'b0 && dozing === 1'b0, "reset");
    t_strobe();
    t_request();
    t_overrun();
    t_doze();
    t_slow();
    results();
  end
  // Watchdog against a hang
  initial begin
    #300000;
    fails++;
    results();
  end
endmodule // tb
